// File: design/ira_pkg.sv
// shared constants and types of the serial register access port
`default_nettype none
package ira_pkg;
    // ------------------------------------------------------------
    // device register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_COMMAND = 8'h00;
    localparam logic [7:0] REG_RESULT_1 = 8'h01;
    localparam logic [7:0] REG_RESULT_4 = 8'h04;
    localparam logic [7:0] REG_ALERT_1 = 8'h05;
    localparam logic [7:0] REG_ALERT_3 = 8'h07;
    localparam logic [7:0] REG_CHAN_SEQ = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h09;
    localparam logic [7:0] REG_POWER_DOWN = 8'h0A;
    localparam logic [7:0] REG_LIMIT_FIRST = 8'h0B;
    localparam logic [7:0] REG_LIMIT_LAST = 8'h25;
    localparam logic [7:0] REG_TOFFS_1 = 8'h26;
    localparam logic [7:0] REG_TOFFS_2 = 8'h27;
    localparam logic [7:0] REG_LIMIT = 8'h28;
    localparam int REG_COUNT = 40;
    localparam int CFG_AUTO_BIT = 12;
    // ------------------------------------------------------------
    // slave address straps
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h61;
    localparam logic [6:0] STRAP_W2 = 7'h09;
    localparam logic [6:0] STRAP_W1 = 7'h03;
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_HIGH = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
    // ------------------------------------------------------------
    // host command port on apb
    // ------------------------------------------------------------
    localparam logic [31:0] APB_CMD_OFS = 32'h0000_0000;
    localparam logic [31:0] APB_STATUS_OFS = 32'h0000_0004;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int CMD_READ_BIT = 10;
    localparam int CMD_NACK_BIT = 11;
    localparam int CMD_SKIP_BIT = 12;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    // short line period keeps a full bench run under ten thousand cycles
    localparam int SCL_PERIOD_NS = 160;
    localparam logic [7:0] SCL_QUARTER_CYC =
        8'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DS_IDLE, DS_ADDR, DS_RX, DS_ACK, DS_TX, DS_TXACK, DS_SKIP
    } ira_dst_t;
    typedef enum logic [1:0] {
        HS_IDLE, HS_START, HS_BIT, HS_STOP
    } ira_hst_t;

    function automatic logic ira_is_byte_reg(input logic [7:0] a);
        return a == REG_COMMAND || (a >= REG_ALERT_1 && a <= REG_CHAN_SEQ)
            || a == REG_POWER_DOWN || a == REG_TOFFS_1 || a == REG_TOFFS_2;
    endfunction

    function automatic logic [6:0] ira_strap_addr(input logic [5:0] s);
        return SLAVE_ADDR_BASE + {5'h00, s[5:4]} * STRAP_W2
            + {5'h00, s[3:2]} * STRAP_W1 + {5'h00, s[1:0]};
    endfunction
endpackage
`default_nettype wire

// File: design/ira_i2c_if.sv
// open-drain two-wire link joining host and device
`default_nettype none
interface ira_i2c_if;
    logic scl_o;
    logic scl_oe;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;
    // wired-and: a line is low if any enabled driver pulls it low
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));
    modport master (input scl, input sda, output scl_o, output scl_oe,
                    output sda_o_m, output sda_oe_m);
    modport slave (input scl, input sda, output sda_o_s, output sda_oe_s);
endinterface
`default_nettype wire

// File: design/ira_dev.sv
// device end: two-wire slave with pointer and register file
// ------------------------------------------------------------
// How it works
// - byte registers take one data byte
// - wide registers take two data bytes
// - start, address, pointer, data, acks, stop
// - wide write sends upper byte first
// - more pointer and data pairs may follow
// - master sets pointer before reading
// - unlimited reads from one pointer
// - pointer survives end of transaction
// - new pointer write selects another register
// - byte register repeats its byte
// - wide register returns upper, lower pairs
// - on nack release data line
// - master nacks only the last byte
// - command mode and autocycle mode offered
// - one direction per transaction; here a repeated start may switch direction
// - three-level straps pick the address
// ------------------------------------------------------------
`default_nettype none
module ira_dev
    import ira_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ira_i2c_if.slave bus,
    input wire logic [5:0] addr_strap,
    output logic cmd_start,
    output logic autocycle_en
);
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        ira_dst_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] msb;
        logic [7:0] ptr;
        logic [1:0] ph;
        logic rd;
        logic hl;
        logic mack;
        logic sda_oe;
        logic cmd_pulse;
        logic auto_en;
        logic strap_done;
        logic [6:0] own;
        logic [REG_COUNT-1:0][15:0] regs;
    } ira_dev_state_t;

    ira_dev_state_t st_q;
    ira_dev_state_t st_d;
    logic [15:0] cur_v;
    logic cur_byte;
    logic [7:0] byte_hi;
    logic [7:0] byte_lo;

    // ------------------------------------------------------------
    // read data of the pointed register
    // ------------------------------------------------------------
    // unmapped pointers read as zero rather than aliasing
    assign cur_v = (st_q.ptr < REG_LIMIT) ? st_q.regs[st_q.ptr[5:0]]
                                          : 16'h0000;
    assign cur_byte = ira_is_byte_reg(st_q.ptr);
    assign byte_lo = cur_v[7:0];
    assign byte_hi = cur_byte ? cur_v[7:0] : cur_v[15:8];

    always_comb begin
        logic nscl;
        logic nsda;
        logic rise;
        logic fall;
        logic sta;
        logic sto;
        logic [7:0] nb;
        nscl = 1'b0;
        nsda = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        sta = 1'b0;
        sto = 1'b0;
        nb = 8'h00;
        st_d = st_q;
        st_d.cmd_pulse = 1'b0;
        // --------------------------------------------------------
        // input filter: a change counts once two stages agree
        // --------------------------------------------------------
        st_d.scl_s = {st_q.scl_s[1:0], bus.scl};
        st_d.sda_s = {st_q.sda_s[1:0], bus.sda};
        nscl = (st_q.scl_s[1] == st_q.scl_s[2]) ? st_q.scl_s[2]
                                                : st_q.scl_f;
        nsda = (st_q.sda_s[1] == st_q.sda_s[2]) ? st_q.sda_s[2]
                                                : st_q.sda_f;
        st_d.scl_f = nscl;
        st_d.sda_f = nsda;
        rise = ~st_q.scl_f & nscl;
        fall = st_q.scl_f & ~nscl;
        sta = st_q.scl_f & nscl & st_q.sda_f & ~nsda;
        sto = st_q.scl_f & nscl & ~st_q.sda_f & nsda;
        // --------------------------------------------------------
        // address straps, caught once after reset release
        // --------------------------------------------------------
        if (!st_q.strap_done) begin
            st_d.own = ira_strap_addr(addr_strap);
            st_d.strap_done = 1'b1;
        end
        // conversion logic lives elsewhere; only the triggers leave here
        st_d.auto_en = st_q.regs[REG_CONFIG[5:0]][CFG_AUTO_BIT]
            & (|st_q.regs[REG_CHAN_SEQ[5:0]][7:0]);
        // --------------------------------------------------------
        // link state machine
        // --------------------------------------------------------
        if (sto) begin
            st_d.st = DS_IDLE;
            st_d.sda_oe = 1'b0;
        end else if (sta) begin
            // repeated start may change direction, pointer is kept
            st_d.st = DS_ADDR;
            st_d.cnt = 4'h0;
            st_d.sda_oe = 1'b0;
        end else begin
            unique case (st_q.st)
                DS_IDLE, DS_SKIP: begin
                    st_d.sda_oe = 1'b0;
                end
                DS_ADDR, DS_RX: begin
                    if (rise) begin
                        st_d.sh = {st_q.sh[6:0], nsda};
                        st_d.cnt = st_q.cnt + 4'h1;
                    end
                    if (fall && st_q.cnt == 4'h8) begin
                        st_d.st = DS_ACK;
                        st_d.sda_oe = 1'b1;
                        if (st_q.st == DS_ADDR) begin
                            st_d.rd = st_q.sh[0];
                            st_d.ph = 2'h0;
                            st_d.hl = 1'b0;
                            if (st_q.sh[7:1] != st_q.own) begin
                                st_d.st = DS_SKIP;
                                st_d.sda_oe = 1'b0;
                            end
                        end else begin
                            unique case (st_q.ph)
                                2'h0: begin
                                    st_d.ptr = st_q.sh;
                                    st_d.ph = 2'h1;
                                end
                                2'h1: begin
                                    if (cur_byte) begin
                                        if (st_q.ptr < REG_LIMIT) begin
                                            st_d.regs[st_q.ptr[5:0]] =
                                                {8'h00, st_q.sh};
                                        end
                                        st_d.cmd_pulse =
                                            (st_q.ptr == REG_COMMAND);
                                        st_d.ph = 2'h0;
                                    end else begin
                                        st_d.msb = st_q.sh;
                                        st_d.ph = 2'h2;
                                    end
                                end
                                2'h2: begin
                                    if (st_q.ptr < REG_LIMIT) begin
                                        st_d.regs[st_q.ptr[5:0]] =
                                            {st_q.msb, st_q.sh};
                                    end
                                    st_d.ph = 2'h0;
                                end
                                default: begin
                                    st_d.ph = 2'h0;
                                end
                            endcase
                        end
                    end
                end
                DS_ACK: begin
                    if (fall) begin
                        st_d.cnt = 4'h0;
                        if (st_q.rd) begin
                            st_d.st = DS_TX;
                            st_d.sh = byte_hi;
                            st_d.sda_oe = ~byte_hi[7];
                        end else begin
                            st_d.st = DS_RX;
                            st_d.sda_oe = 1'b0;
                        end
                    end
                end
                DS_TX: begin
                    if (fall) begin
                        st_d.cnt = st_q.cnt + 4'h1;
                        if (st_q.cnt == 4'h7) begin
                            st_d.st = DS_TXACK;
                            st_d.sda_oe = 1'b0;
                        end else begin
                            st_d.sh = {st_q.sh[6:0], 1'b0};
                            st_d.sda_oe = ~st_q.sh[6];
                        end
                    end
                end
                DS_TXACK: begin
                    if (rise) begin
                        st_d.mack = ~nsda;
                    end
                    if (fall) begin
                        if (st_q.mack) begin
                            nb = st_q.hl ? byte_hi : byte_lo;
                            st_d.hl = ~st_q.hl;
                            st_d.st = DS_TX;
                            st_d.cnt = 4'h0;
                            st_d.sh = nb;
                            st_d.sda_oe = ~nb[7];
                        end else begin
                            st_d.st = DS_SKIP;
                            st_d.sda_oe = 1'b0;
                        end
                    end
                end
                default: begin
                    st_d.st = DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // filters start at the idle level: no false edge after reset
            st_q <= '0;
            st_q.scl_s <= 3'h7;
            st_q.sda_s <= 3'h7;
            st_q.scl_f <= 1'b1;
            st_q.sda_f <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.sda_oe_s = st_q.sda_oe;
    assign bus.sda_o_s = 1'b0;
    assign cmd_start = st_q.cmd_pulse;
    assign autocycle_en = st_q.auto_en;
endmodule
`default_nettype wire

// File: design/ira_host.sv
// host end: byte-level two-wire master driven over apb
`default_nettype none
module ira_host
    import ira_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ira_i2c_if.master bus
);
    typedef struct packed {
        logic [2:0] sda_s;
        logic sda_f;
        ira_hst_t st;
        logic [7:0] qc;
        logic [1:0] qi;
        logic [3:0] bitn;
        logic [7:0] tx;
        logic [7:0] rx;
        logic f_start;
        logic f_stop;
        logic f_read;
        logic f_nack;
        logic f_skip;
        logic busy;
        logic got_nack;
        logic scl_oe;
        logic sda_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ira_host_state_t;

    ira_host_state_t st_q;
    ira_host_state_t st_d;

    always_comb begin
        logic tick;
        logic wr;
        tick = 1'b0;
        wr = 1'b0;
        st_d = st_q;
        // --------------------------------------------------------
        // data line filter
        // --------------------------------------------------------
        st_d.sda_s = {st_q.sda_s[1:0], bus.sda};
        if (st_q.sda_s[1] == st_q.sda_s[2]) begin
            st_d.sda_f = st_q.sda_s[2];
        end
        // --------------------------------------------------------
        // apb slave, zero wait states
        // --------------------------------------------------------
        st_d.pready = psel & ~penable;
        if (psel && !penable) begin
            st_d.pslverr = 1'b0;
            st_d.prdata = 32'h0000_0000;
            if (paddr == APB_STATUS_OFS) begin
                st_d.prdata = {16'h0000, st_q.rx, 6'h00,
                               st_q.got_nack, st_q.busy};
            end else if (paddr == APB_CMD_OFS) begin
                st_d.prdata = {19'h0_0000, st_q.f_skip, st_q.f_nack,
                               st_q.f_read, st_q.f_stop, st_q.f_start,
                               st_q.tx};
            end else begin
                st_d.pslverr = 1'b1;
            end
        end
        wr = psel & penable & pwrite & st_q.pready & ~st_q.pslverr
            & (paddr == APB_CMD_OFS);
        // a command while busy is dropped; software polls busy first
        if (wr && !st_q.busy) begin
            st_d.tx = pwdata[7:0];
            st_d.f_start = pwdata[CMD_START_BIT];
            st_d.f_stop = pwdata[CMD_STOP_BIT];
            st_d.f_read = pwdata[CMD_READ_BIT];
            st_d.f_nack = pwdata[CMD_NACK_BIT];
            st_d.f_skip = pwdata[CMD_SKIP_BIT];
            st_d.busy = 1'b1;
            st_d.qc = 8'h00;
            st_d.qi = 2'h0;
            st_d.bitn = 4'h0;
            st_d.got_nack = 1'b0;
            if (pwdata[CMD_START_BIT]) begin
                st_d.st = HS_START;
            end else if (!pwdata[CMD_SKIP_BIT]) begin
                st_d.st = HS_BIT;
            end else if (pwdata[CMD_STOP_BIT]) begin
                st_d.st = HS_STOP;
            end else begin
                st_d.busy = 1'b0;
            end
        end
        // --------------------------------------------------------
        // bit engine, four quarters per line clock
        // --------------------------------------------------------
        // no clock stretching: the slave is assumed never to hold scl
        if (st_q.st != HS_IDLE) begin
            tick = (st_q.qc == SCL_QUARTER_CYC - 8'h01);
            st_d.qc = tick ? 8'h00 : st_q.qc + 8'h01;
        end
        if (tick) begin
            st_d.qi = st_q.qi + 2'h1;
            unique case (st_q.st)
                HS_START: begin
                    unique case (st_q.qi)
                        2'h0: st_d.sda_oe = 1'b0;
                        2'h1: st_d.scl_oe = 1'b0;
                        2'h2: st_d.sda_oe = 1'b1;
                        2'h3: begin
                            st_d.scl_oe = 1'b1;
                            st_d.bitn = 4'h0;
                            if (!st_q.f_skip) begin
                                st_d.st = HS_BIT;
                            end else if (st_q.f_stop) begin
                                st_d.st = HS_STOP;
                            end else begin
                                st_d.st = HS_IDLE;
                                st_d.busy = 1'b0;
                            end
                        end
                    endcase
                end
                HS_BIT: begin
                    unique case (st_q.qi)
                        2'h0: begin
                            if (st_q.bitn < 4'h8) begin
                                st_d.sda_oe = ~st_q.f_read & ~st_q.tx[7];
                            end else begin
                                st_d.sda_oe = st_q.f_read & ~st_q.f_nack;
                            end
                        end
                        2'h1: st_d.scl_oe = 1'b0;
                        2'h2: begin
                            if (st_q.bitn < 4'h8) begin
                                st_d.rx = {st_q.rx[6:0], st_q.sda_f};
                            end else if (!st_q.f_read) begin
                                st_d.got_nack = st_q.sda_f;
                            end
                        end
                        2'h3: begin
                            st_d.scl_oe = 1'b1;
                            st_d.tx = {st_q.tx[6:0], 1'b0};
                            st_d.bitn = st_q.bitn + 4'h1;
                            if (st_q.bitn == 4'h8) begin
                                if (st_q.f_stop) begin
                                    st_d.st = HS_STOP;
                                end else begin
                                    st_d.st = HS_IDLE;
                                    st_d.busy = 1'b0;
                                end
                            end
                        end
                    endcase
                end
                HS_STOP: begin
                    unique case (st_q.qi)
                        2'h0: st_d.sda_oe = 1'b1;
                        2'h1: st_d.scl_oe = 1'b0;
                        2'h2: st_d.sda_oe = 1'b0;
                        2'h3: begin
                            st_d.st = HS_IDLE;
                            st_d.busy = 1'b0;
                        end
                    endcase
                end
                HS_IDLE: begin
                    st_d.st = HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // data filter starts at the released level
            st_q <= '0;
            st_q.sda_s <= 3'h7;
            st_q.sda_f <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign bus.scl_oe = st_q.scl_oe;
    assign bus.scl_o = 1'b0;
    assign bus.sda_oe_m = st_q.sda_oe;
    assign bus.sda_o_m = 1'b0;
endmodule
`default_nettype wire

// File: bench/ira_link_chk.sv
// assertion checker on the two-wire link between host and device
`default_nettype none
module ira_link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe,
    input wire logic sda_oe_m,
    input wire logic sda_oe_s
);
    // ----
    // bit and frame tracking
    // ----
    logic scl_q, sda_q, fb_q, rd_q, am_q, nk_q, rise, frame;
    logic [3:0] bc_q;
    assign rise = scl & ~scl_q;
    // sda edge while scl high: start or stop
    assign frame = scl & scl_q & (sda ^ sda_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {scl_q, sda_q} <= 2'h3;
            {fb_q, rd_q, am_q, nk_q} <= 4'h0;
            bc_q <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (frame) begin
                {fb_q, am_q, nk_q} <= {~sda, 2'h0};
                bc_q <= 4'h0;
            end else if (rise) begin
                bc_q <= (bc_q == 4'h8) ? 4'h0 : bc_q + 4'h1;
                if (fb_q && bc_q == 4'h7) rd_q <= sda;
                if (fb_q && bc_q == 4'h8) am_q <= ~sda;
                if (bc_q == 4'h8) fb_q <= 1'b0;
                if (rd_q && !fb_q && bc_q == 4'h8 && sda) nk_q <= 1'b1;
            end
        end
    end
    // ----
    // properties
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_released;
        ##[1:8] !sda_oe_s;
    endsequence
    slave_edge_a: assert property ($changed(sda_oe_s) |->
        !scl && !$past(scl, 2)) else $error("slave moved sda, scl high");
    nack_release_a: assert property (nk_q |-> !sda_oe_s)
        else $error("slave drives sda after nack");
    read_ack_a: assert property (rise && bc_q == 4'h8 && rd_q && !fb_q
        |-> !sda_oe_s) else $error("slave drives master ack slot");
    write_ack_a: assert property (rise && bc_q == 4'h8 && !rd_q && !fb_q
        && am_q |-> sda_oe_s) else $error("written byte not acked");
    foreign_quiet_a: assert property (!am_q && !fb_q |-> !sda_oe_s)
        else $error("slave drives sda when not addressed");
    frame_master_a: assert property (frame |-> !sda_oe_s)
        else $error("start or stop made by slave");
    data_stable_a: assert property ($rose(scl) |=>
        $stable(sda_oe_m) [*8]) else $error("master moved sda, scl high");
    ack_release_a: assert property ($fell(scl) && bc_q == 4'h0 && !fb_q
        && !rd_q && am_q |-> s_released) else $error("ack held too long");
endmodule
`default_nettype wire

// File: bench/tb_i2c_register_access_port.sv
// self-checking bench: apb host end talking to the device end
`default_nettype none
module tb_i2c_register_access_port import ira_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, st;
    logic pready, pslverr, err, cmd_start, auto_en;
    int n_mismatch = 0, checks_done = 0, cyc = 0, n_cmd = 0;
    localparam logic [6:0] DEV = 7'h76;
    ira_i2c_if link();
    ira_host ira_host_i(.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .bus(link));
    // strap: float, high, low
    ira_dev ira_dev_i(.pclk, .presetn, .bus(link), .addr_strap(6'h24),
        .cmd_start, .autocycle_en(auto_en));
    ira_link_chk ira_link_chk_i(.pclk, .presetn, .scl(link.scl),
        .sda(link.sda), .scl_oe(link.scl_oe), .sda_oe_m(link.sda_oe_m),
        .sda_oe_s(link.sda_oe_s));
    always #2 pclk = ~pclk;
    // count command pulses; sampled at the edge, before it moves
    always @(posedge pclk) begin
        if (cmd_start === 1'b1) begin
            n_cmd <= n_cmd + 1;
        end
    end
    // ----
    // tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        st = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, input logic s, p, rd, nk);
        logic [31:0] c;
        c = {24'h00_0000, b};
        c[CMD_START_BIT] = s;
        c[CMD_STOP_BIT] = p;
        c[CMD_READ_BIT] = rd;
        c[CMD_NACK_BIT] = nk;
        apb(1'b1, APB_CMD_OFS, c);
        do apb(1'b0, APB_STATUS_OFS, '0); while (st[STAT_BUSY_BIT] !== 1'b0);
    endtask
    task automatic wr(input logic [7:0] b, input logic s, p);
        xfer(b, s, p, 1'b0, 1'b0);
        chk("ack", {15'h0000, st[STAT_NACK_BIT]}, 16'h0000);
    endtask
    task automatic rdb(input logic [7:0] e, input logic last);
        xfer(8'h00, 1'b0, last, 1'b1, last);
        chk("rdata", {8'h00, st[15:8]}, {8'h00, e});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_write;
        apb(1'b1, 32'h0000_0010, 32'h0000_0001);
        chk("slverr", {15'h0000, err}, 16'h0001);
        wr({DEV, 1'b0}, 1'b1, 1'b0);
        wr(REG_CONFIG, 1'b0, 1'b0);
        wr(8'h10, 1'b0, 1'b0);
        wr(8'h00, 1'b0, 1'b0);
        wr(REG_CHAN_SEQ, 1'b0, 1'b0);
        wr(8'h05, 1'b0, 1'b1);
        chk("auto", {15'h0000, auto_en}, 16'h0001);
        $display("write test done");
    endtask
    task automatic t_read8;
        wr({DEV, 1'b1}, 1'b1, 1'b0);
        rdb(8'h05, 1'b0);
        rdb(8'h05, 1'b1);
        wr({DEV, 1'b1}, 1'b1, 1'b0);
        rdb(8'h05, 1'b1);
        $display("byte read test done");
    endtask
    task automatic t_read16;
        wr({DEV, 1'b0}, 1'b1, 1'b0);
        wr(REG_CONFIG, 1'b0, 1'b1);
        wr({DEV, 1'b1}, 1'b1, 1'b0);
        rdb(8'h10, 1'b0);
        rdb(8'h00, 1'b0);
        rdb(8'h10, 1'b1);
        xfer({7'h61, 1'b0}, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("foreign", {15'h0000, st[STAT_NACK_BIT]}, 16'h0001);
        $display("wide read test done");
    endtask
    task automatic t_cmd;
        logic [31:0] c;
        c = '0;
        c[CMD_SKIP_BIT] = 1'b1;
        c[CMD_STOP_BIT] = 1'b1;
        wr({DEV, 1'b0}, 1'b1, 1'b0);
        wr(REG_COMMAND, 1'b0, 1'b0);
        wr(8'h13, 1'b0, 1'b0);
        // stop alone, no byte on the link
        apb(1'b1, APB_CMD_OFS, c);
        do apb(1'b0, APB_STATUS_OFS, '0); while (st[STAT_BUSY_BIT] !== 1'b0);
        chk("cmd_pulse", n_cmd[15:0], 16'h0001);
        apb(1'b0, APB_CMD_OFS, '0);
        chk("cmd_back", st[15:0], c[15:0]);
        wr({DEV, 1'b1}, 1'b1, 1'b0);
        rdb(8'h13, 1'b0);
        rdb(8'h13, 1'b1);
        chk("cmd_pulse", n_cmd[15:0], 16'h0001);
        $display("command test done");
    endtask
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        t_write;
        t_read8;
        t_read16;
        t_cmd;
        test_done;
    end
    // about 25 link bytes of 360 cycles each fit well below this
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            test_done;
        end
    end
endmodule
`default_nettype wire
